// file: core/osfs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "osfs_consts.vh"
module osfs_top (
  input wire REF_CLK_I,
  input wire SYS_RST_I,
  input wire OSC_CLK_I,
  input wire [11:0] AWADDR_I,
  input wire AWVALID_I,
  output reg AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output reg WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  input wire [11:0] ARADDR_I,
  input wire ARVALID_I,
  output reg ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I,
  output reg LOW_OK_O,
  output reg HIGH_OK_O,
  output reg IRQ_O
);
  localparam CW = 12;
  localparam [1:0] RESP_OK = 2'h0;
  localparam [1:0] RESP_ERR = 2'h2;

  // --------------------------------------------------------------------------
  // Threshold arithmetic
  // --------------------------------------------------------------------------
  // Everything is compared in hundredths of a MHz: the gate lasts 10 us, so
  // the edge count times ten is the oscillator frequency in those units.
  function [15:0] scale;
    input [5:0] nom;
    input [7:0] mul;
    begin
      scale = {10'h000, nom} * {8'h00, mul};
    end
  endfunction

  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr == `OSFS_OFF_CTRL) || (addr == `OSFS_OFF_IRQ_STAT) ||
               (addr == `OSFS_OFF_IRQ_MASK) || (addr == `OSFS_OFF_CFG) ||
               (addr == `OSFS_OFF_COUNT);
    end
  endfunction

  reg [4:0] osc_frequency_value_q;
  reg untrimmed_q;
  reg osc_above_low_threshold_flag_q;
  reg osc_below_high_threshold_flag_q;
  reg [`OSFS_EV_BITS-1:0] irq_stat_q;
  reg [`OSFS_EV_BITS-1:0] irq_mask_q;
  reg [CW-1:0] last_count_q;
  reg [11:0] aw_addr_q;
  reg aw_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_held_q;
  wire [CW-1:0] meas_count;
  wire meas_done;
  wire [5:0] nominal_mhz;
  wire [15:0] meas_centi;
  wire [15:0] low_thr;
  wire [15:0] high_thr;
  wire low_ok;
  wire high_ok;
  wire do_write;
  wire [31:0] ctrl_word;
  reg [`OSFS_EV_BITS-1:0] events;
  reg [31:0] rd_word;

  osfs_freq_meter #(
    .GATE_CYCLES(`OSFS_GATE_CYCLES),
    .CW(CW)
  ) u_meter (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .osc_i(OSC_CLK_I),
    .count_o(meas_count),
    .done_o(meas_done)
  );

  assign nominal_mhz = {1'b0, osc_frequency_value_q} + `OSFS_VAL_OFFSET;
  assign meas_centi = {4'h0, meas_count} * `OSFS_COUNT_SCALE;
  assign low_thr = untrimmed_q ?
    scale(nominal_mhz, `OSFS_LOW_MUL_RAW) - {8'h00, `OSFS_LOW_SUB_RAW} :
    scale(nominal_mhz, `OSFS_LOW_MUL_TRIM) - {8'h00, `OSFS_LOW_SUB_TRIM};
  assign high_thr = untrimmed_q ?
    scale(nominal_mhz, `OSFS_HIGH_MUL_RAW) + {8'h00, `OSFS_HIGH_ADD_RAW} :
    scale(nominal_mhz, `OSFS_HIGH_MUL_TRIM) + {8'h00, `OSFS_HIGH_ADD_TRIM};
  assign low_ok = meas_centi > low_thr;
  assign high_ok = meas_centi < high_thr;

  // --------------------------------------------------------------------------
  // Supervision flags and events
  // --------------------------------------------------------------------------
  // Flags change only at the end of a gate, so a read never sees a half count.
  always @* begin
    events = {`OSFS_EV_BITS{1'b0}};
    events[`OSFS_EV_MEAS_DONE] = meas_done;
    events[`OSFS_EV_LOW_LOST] = meas_done && osc_above_low_threshold_flag_q && !low_ok;
    events[`OSFS_EV_HIGH_LOST] = meas_done && osc_below_high_threshold_flag_q && !high_ok;
  end

  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      osc_above_low_threshold_flag_q <= 1'b0;
      osc_below_high_threshold_flag_q <= 1'b0;
      last_count_q <= {CW{1'b0}};
      LOW_OK_O <= 1'b0;
      HIGH_OK_O <= 1'b0;
    end else if (meas_done) begin
      osc_above_low_threshold_flag_q <= low_ok;
      osc_below_high_threshold_flag_q <= high_ok;
      last_count_q <= meas_count;
      LOW_OK_O <= low_ok;
      HIGH_OK_O <= high_ok;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  assign do_write = aw_held_q && w_held_q && !BVALID_O;
  assign ctrl_word = {11'h000, osc_frequency_value_q, 7'h00,
                      osc_below_high_threshold_flag_q, 6'h00,
                      osc_above_low_threshold_flag_q, 1'b0};

  always @* begin
    case (ARADDR_I)
      `OSFS_OFF_CTRL: rd_word = ctrl_word;
      `OSFS_OFF_IRQ_STAT: rd_word = {29'h0, irq_stat_q};
      `OSFS_OFF_IRQ_MASK: rd_word = {29'h0, irq_mask_q};
      `OSFS_OFF_CFG: rd_word = {31'h0, untrimmed_q};
      `OSFS_OFF_COUNT: rd_word = {20'h0, last_count_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      BVALID_O <= 1'b0;
      BRESP_O <= RESP_OK;
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RRESP_O <= RESP_OK;
      RDATA_O <= 32'h0000_0000;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      osc_frequency_value_q <= `OSFS_VAL_RST;
      untrimmed_q <= 1'b0;
      irq_mask_q <= {`OSFS_EV_BITS{1'b0}};
      irq_stat_q <= {`OSFS_EV_BITS{1'b0}};
      IRQ_O <= 1'b0;
    end else begin
      AWREADY_O <= !aw_held_q && !(AWVALID_I && AWREADY_O);
      WREADY_O <= !w_held_q && !(WVALID_I && WREADY_O);
      if (AWVALID_I && AWREADY_O) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_held_q <= 1'b1;
        w_data_q <= WDATA_I;
        w_strb_q <= WSTRB_I;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= mapped(aw_addr_q) ? RESP_OK : RESP_ERR;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
      // Only the value field is writable in control; the flags ignore writes.
      if (do_write && aw_addr_q == `OSFS_OFF_CTRL && w_strb_q[2]) begin
        osc_frequency_value_q <= w_data_q[`OSFS_CTRL_VAL_MSB:`OSFS_CTRL_VAL_LSB];
      end
      if (do_write && aw_addr_q == `OSFS_OFF_CFG && w_strb_q[0]) begin
        untrimmed_q <= w_data_q[0];
      end
      if (do_write && aw_addr_q == `OSFS_OFF_IRQ_MASK && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[`OSFS_EV_BITS-1:0];
      end
      // A new event outranks a write-one-to-clear landing in the same cycle.
      if (do_write && aw_addr_q == `OSFS_OFF_IRQ_STAT && w_strb_q[0]) begin
        irq_stat_q <= (irq_stat_q & ~w_data_q[`OSFS_EV_BITS-1:0]) | events;
      end else begin
        irq_stat_q <= irq_stat_q | events;
      end
      IRQ_O <= |(irq_stat_q & irq_mask_q);
      ARREADY_O <= !RVALID_O && !(ARVALID_I && ARREADY_O);
      if (ARVALID_I && ARREADY_O) begin
        RVALID_O <= 1'b1;
        RDATA_O <= rd_word;
        RRESP_O <= mapped(ARADDR_I) ? RESP_OK : RESP_ERR;
      end else if (RVALID_O && RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/osfs_consts.vh
`ifndef OSFS_CONSTS_VH
`define OSFS_CONSTS_VH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OSFS_OFF_CTRL 12'h000
`define OSFS_OFF_IRQ_STAT 12'h004
`define OSFS_OFF_IRQ_MASK 12'h008
`define OSFS_OFF_CFG 12'h00c
`define OSFS_OFF_COUNT 12'h010
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define OSFS_CTRL_LOW_BIT 1
`define OSFS_CTRL_HIGH_BIT 8
`define OSFS_CTRL_VAL_LSB 16
`define OSFS_CTRL_VAL_MSB 20
`define OSFS_VAL_RST 5'h09
`define OSFS_VAL_OFFSET 6'h0f
`define OSFS_EV_LOW_LOST 0
`define OSFS_EV_HIGH_LOST 1
`define OSFS_EV_MEAS_DONE 2
`define OSFS_EV_BITS 3
// ----------------------------------------------------------------------------
// Threshold coefficients, in hundredths
// ----------------------------------------------------------------------------
`define OSFS_LOW_MUL_TRIM 8'h4b
`define OSFS_LOW_SUB_TRIM 8'h1f
`define OSFS_LOW_MUL_RAW 8'h35
`define OSFS_LOW_SUB_RAW 8'h27
`define OSFS_HIGH_MUL_TRIM 8'h92
`define OSFS_HIGH_ADD_TRIM 8'h1d
`define OSFS_HIGH_MUL_RAW 8'hba
`define OSFS_HIGH_ADD_RAW 8'h15
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OSFS_CLK_PERIOD_NS 5
`define OSFS_GATE_TIME_NS 10000
`define OSFS_GATE_CYCLES (`OSFS_GATE_TIME_NS / `OSFS_CLK_PERIOD_NS)
`define OSFS_COUNT_SCALE 16'h000a
`endif

// file: core/osfs_freq_meter.v
`timescale 1ns/1ps
`default_nettype none
`include "osfs_consts.vh"
module osfs_freq_meter #(
  parameter GATE_CYCLES = `OSFS_GATE_CYCLES,
  parameter CW = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire osc_i,
  output reg [CW-1:0] count_o,
  output reg done_o
);
  reg [2:0] sync_q;
  reg stable_q;
  reg [11:0] gate_q;
  reg [CW-1:0] edges_q;
  wire agree;
  wire rise;
  wire gate_end;

  // A level is only trusted once the last two stages agree, so a sample taken
  // right at a transition cannot register as two edges.
  assign agree = (sync_q[1] == sync_q[2]);
  assign rise = agree && sync_q[2] && !stable_q;
  assign gate_end = (gate_q == GATE_CYCLES - 1);

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 3'h0;
      stable_q <= 1'b0;
      gate_q <= 12'h000;
      edges_q <= {CW{1'b0}};
      count_o <= {CW{1'b0}};
      done_o <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], osc_i};
      if (agree) begin
        stable_q <= sync_q[2];
      end
      done_o <= gate_end;
      if (gate_end) begin
        gate_q <= 12'h000;
        count_o <= edges_q + {{(CW-1){1'b0}}, rise};
        edges_q <= {CW{1'b0}};
      end else begin
        gate_q <= gate_q + 12'h001;
        if (rise) begin
          edges_q <= edges_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/osfs_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module osfs_osc_model (
  input wire logic [15:0] half_ps_i,
  output logic osc_o
);
  // A zero half period stands for a dead crystal, so the pin parks low.
  always #(half_ps_i == 16'h0 ? 1.0 : half_ps_i * 0.001)
    osc_o = (half_ps_i != 16'h0) && (osc_o !== 1'b1);
endmodule
`default_nettype wire

// file: testbench/osfs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module osfs_checker (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [11:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic LOW_OK_O,
  input wire logic HIGH_OK_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire logic ar_hs = ARVALID_I && ARREADY_O;
  AST_B_HOLD: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
    else $error("bvalid dropped");
  AST_R_HOLD: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data moved");
  // Both halves are parked for one cycle before the write commits and answers.
  AST_B_AFTER: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
    |-> ##2 BVALID_O)
    else $error("no write response");
  AST_R_AFTER: assert property (ar_hs |=> RVALID_O && !ARREADY_O)
    else $error("no read response");
  AST_CTRL_FLAGS: assert property (ar_hs && ARADDR_I == 12'h000 |=>
    RDATA_O[1] == $past(LOW_OK_O) && RDATA_O[8] == $past(HIGH_OK_O)
    && {RDATA_O[31:21], RDATA_O[15:9], RDATA_O[7:2], RDATA_O[0]} == 25'h0)
    else $error("control read wrong");
  AST_UNMAP: assert property (ar_hs && ARADDR_I > 12'h010 |=> RRESP_O == 2'b10 && RDATA_O == 0)
    else $error("unmapped read wrong");
  // Flags only move at gate ends, so a change is followed by a quiet stretch.
  AST_FLAG_SETTLE: assert property ($changed({LOW_OK_O, HIGH_OK_O}) |=>
    $stable({LOW_OK_O, HIGH_OK_O})[*8])
    else $error("flags toggled inside a gate");
  AST_RST: assert property (disable iff (1'b0) SYS_RST_I |=>
    !BVALID_O && !RVALID_O && !IRQ_O && !LOW_OK_O && !HIGH_OK_O)
    else $error("outputs active after reset");
  cover property (BVALID_O && !BREADY_I);
  cover property ($rose(IRQ_O));
  cover property ($fell(LOW_OK_O));
endmodule
bind osfs_top osfs_checker u_osfs_checker (.*);
`default_nettype wire

// file: testbench/oscillator_frequency_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
module oscillator_frequency_supervisor_test;
  logic REF_CLK_I = 1'b0, SYS_RST_I = 1'b1, OSC_CLK_I;
  logic AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
  logic ARVALID_I = 1'b0, RREADY_I = 1'b0;
  logic [11:0] AWADDR_I = 12'h000, ARADDR_I = 12'h000;
  logic [31:0] WDATA_I = 32'h0, RDATA_O, rdat;
  logic [3:0] WSTRB_I = 4'hf;
  logic [1:0] BRESP_O, RRESP_O, rsp;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, LOW_OK_O, HIGH_OK_O, IRQ_O;
  logic [15:0] half_ps = 16'h5161;
  int bad_count = 0;
  int checked = 0;
  osfs_top u_osfs_top (.*);
  osfs_osc_model u_osfs_osc_model (.half_ps_i(half_ps), .osc_o(OSC_CLK_I));
  always #2.5 REF_CLK_I = ~REF_CLK_I;
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    bit ap = 1'b1;
    bit wp = 1'b1;
    @(posedge REF_CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    while (ap || wp) begin
      @(posedge REF_CLK_I);
      ap = ap && AWREADY_O !== 1'b1;
      wp = wp && WREADY_O !== 1'b1;
      AWVALID_I <= ap;
      WVALID_I <= wp;
    end
    repeat ($urandom % 3) @(posedge REF_CLK_I);
    BREADY_I <= 1'b1;
    do @(posedge REF_CLK_I); while (BVALID_O !== 1'b1);
    rsp = BRESP_O;
    BREADY_I <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a);
    @(posedge REF_CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    do @(posedge REF_CLK_I); while (ARREADY_O !== 1'b1);
    ARVALID_I <= 1'b0;
    repeat ($urandom % 3) @(posedge REF_CLK_I);
    RREADY_I <= 1'b1;
    do @(posedge REF_CLK_I); while (RVALID_O !== 1'b1);
    rdat = RDATA_O;
    rsp = RRESP_O;
    RREADY_I <= 1'b0;
  endtask
  // Bit 2 marks a case too close to a threshold for the one-edge counting error.
  function automatic logic [2:0] expf(int nom, int f, bit raw);
    int lo = raw ? nom * 53 - 39 : nom * 75 - 31;
    int hi = raw ? nom * 186 + 21 : nom * 146 + 29;
    int dl = f * 100 - lo;
    int dh = f * 100 - hi;
    return {dl * dl < 900 || dh * dh < 900, dh < 0, dl > 0};
  endfunction
  task automatic meas(int v, int f, bit raw);
    logic [2:0] e = expf(v + 15, f, raw);
    wr(12'h000, 32'(v) << 16);
    wr(12'h00c, {31'h0, raw});
    half_ps <= (f == 0) ? 16'h0 : 16'(500000 / f);
    // Two full gates cover the one already running when the crystal changed,
    // plus the last old half period and the synchroniser delay.
    repeat (4030) @(posedge REF_CLK_I);
    chk("flags", {30'h0, e[1:0]}, {30'h0, HIGH_OK_O, LOW_OK_O});
    rd(12'h000);
    chk("ctrl", {11'h0, 5'(v), 7'h0, e[1], 6'h0, e[0], 1'b0}, rdat);
    rd(12'h010);
    chk("count", 32'h1, {31'h0, (rdat + 1 >= f * 10) && (rdat <= f * 10 + 1)});
    $display("test v=%0d f=%0d raw=%0d done", v, f, raw);
  endtask
  task automatic print_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #450000;
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h823c525c));
    repeat (6) @(posedge REF_CLK_I);
    SYS_RST_I <= 1'b0;
    rd(12'h000);
    chk("ctrl_rst", 32'h00090000, rdat);
    rd(12'h100);
    chk("unmap", 32'h2, {rdat[29:0], rsp});
    wr(12'h000, 32'hffffffff);
    chk("bresp_ok", 32'h0, {30'h0, rsp});
    wr(12'h100, 32'hffffffff);
    chk("bresp_err", 32'h2, {30'h0, rsp});
    rd(12'h000);
    chk("ctrl_ro", 32'h001f0000, rdat);
    $display("register test done");
    meas(9, 24, 0);
    meas(9, 10, 0);
    meas(9, 50, 0);
    meas(9, 40, 1);
    meas(9, 0, 0);
    meas(1, 16, 0);
    meas(25, 40, 0);
    for (int i = 0; i < 8; i++) begin
      int v;
      int f;
      bit raw;
      logic [2:0] e;
      do begin
        v = 1 + $urandom % 25;
        // Each pin level must span two samples to be trusted, so stay below 50 MHz.
        f = 8 + $urandom % 42;
        raw = $urandom % 2;
        e = expf(v + 15, f, raw);
      end while (e[2]);
      meas(v, f, raw);
    end
    chk("irq_off", 32'h0, {31'h0, IRQ_O});
    wr(12'h008, 32'h1);
    repeat (2) @(posedge REF_CLK_I);
    chk("irq_on", 32'h1, {31'h0, IRQ_O});
    rd(12'h004);
    chk("stat", 32'h3, rdat & 32'h3);
    wr(12'h004, 32'h3);
    repeat (2) @(posedge REF_CLK_I);
    chk("irq_clr", 32'h0, {31'h0, IRQ_O});
    $display("interrupt test done");
    print_verdict();
  end
endmodule
`default_nettype wire
